// ### include/clock_source_control_defines.vh
/*
  register offsets, field positions, reset values and timing for the clock control block.
  assumes byte addresses on a 12-bit APB address; included by its bare name.
*/
`ifndef CLOCK_SOURCE_CONTROL_DEFINES_VH
`define CLOCK_SOURCE_CONTROL_DEFINES_VH
`define OFS_FAST_XTAL_START 12'h000
`define OFS_FAST_XTAL_STOP 12'h004
`define OFS_SLOW_START 12'h008
`define OFS_SLOW_STOP 12'h00C
`define OFS_CAL_TASK 12'h010
`define OFS_CT_START 12'h014
`define OFS_CT_STOP 12'h018
`define OFS_EV_FAST_STARTED 12'h100
`define OFS_EV_SLOW_STARTED 12'h104
`define OFS_EV_CAL_DONE 12'h10C
`define OFS_EV_CT_TIMEOUT 12'h110
`define OFS_EV_CT_STARTED 12'h128
`define OFS_EV_CT_STOPPED 12'h12C
`define OFS_IRQ_SET 12'h304
`define OFS_IRQ_CLEAR 12'h308
`define OFS_FAST_REQUESTED 12'h408
`define OFS_FAST_STATUS 12'h40C
`define OFS_SLOW_REQUESTED 12'h414
`define OFS_SLOW_STATUS 12'h418
`define OFS_SLOW_SNAPSHOT 12'h41C
`define OFS_SLOW_SELECT 12'h518
`define OFS_FAST_DEBOUNCE 12'h528
`define OFS_SLOW_DEBOUNCE 12'h52C
`define OFS_CT_INTERVAL 12'h538
// event index inside the event vector, and its enable bit position
`define EV_FAST_STARTED 0
`define EV_SLOW_STARTED 1
`define EV_CAL_DONE 2
`define EV_CT_TIMEOUT 3
`define EV_CT_STARTED 4
`define EV_CT_STOPPED 5
`define IEN_FAST_STARTED 0
`define IEN_SLOW_STARTED 1
`define IEN_CAL_DONE 3
`define IEN_CT_TIMEOUT 4
`define IEN_CT_STARTED 10
`define IEN_CT_STOPPED 11
// field positions
`define STATE_BIT 16
`define BYPASS_BIT 16
`define EXTERNAL_BIT 17
// source codes
`define SOURCE_RC 2'h0
`define SOURCE_XTAL 2'h1
`define SOURCE_SYNTH 2'h2
// reset values
`define FAST_DEBOUNCE_RESET 8'h10
`define SLOW_DEBOUNCE_RESET 4'h0
`define CT_INTERVAL_RESET 7'h00
// timing
`define CLK_MHZ 10
`define FAST_POWERUP_US 20
`define FAST_POWERUP_CYCLES (`FAST_POWERUP_US * `CLK_MHZ)
`define CAL_TIME_US 50
`define CAL_CYCLES (`CAL_TIME_US * `CLK_MHZ)
`endif

// ### logic/clock_source_control.v
/*
  clock control: fast clock sourcing, slow clock sourcing and sequencing, rc calibration
  and a count-down calibration timer, behind an APB slave with one wait state.
  assumes clock requests and power-off come in synchronous to clk; oscillator startup
  is modelled by counters, the oscillators themselves sit outside.
*/
// Register access over APB was chosen for this implementation.
// Functional notes
// - fast clock requested with crystal not started is taken from the internal oscillator
// - deliver fast clock only while requested; otherwise sit in power-saving state
// - crystal start/stop tasks; started event after power-up plus debounce time
// - crystal source runs from rc first, switches over, then raises started
// - slow stop task stops the slow clock
// - source 0 rc, 1 crystal, 2 synthesized; external and bypass normally clear
// - crystal with external set, bypass clear: low-swing clock on pin one
// - crystal with external and bypass set: full-swing clock; other mixes forbidden
// - synthesized slow clock derives from the fast clock and its accuracy
// - synthesized source in use keeps a standing fast clock request
// - after reset the rc oscillator is the slow source
// - power-off switches off slow controller and all slow sources
// - calibrate with rc running requests fast clock, then raises done
// - timer start loads interval, counts to 0, times out and stops itself
// - timer ignores tasks until it answers started or stopped
// - start while running or stop while stopped answers at once
// - enable bits set via set register, cleared via clear register, both read back
// - fast status shows source in bit 0 and running state
// - fast start requested reads 1 after start task, 0 otherwise
`include "clock_source_control_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module clock_source_control #(
  parameter CT_TICK_CYCLES = 25000,
  parameter DEBOUNCE_UNIT = 16
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fastClockRequest,
  input wire systemOff,
  output reg fastClockEnable,
  output reg fastFromCrystal,
  output reg fastCrystalOn,
  output reg slowRcOn,
  output reg slowCrystalOn,
  output reg slowCrystalExternal,
  output reg slowCrystalBypass,
  output reg slowSynthOn,
  output reg [1:0] slowActiveSource,
  output reg irq
);
  localparam HX_OFF = 3'b001;
  localparam HX_START = 3'b010;
  localparam HX_RUN = 3'b100;
  localparam LF_OFF = 3'b001;
  localparam LF_WARM = 3'b010;
  localparam LF_RUN = 3'b100;
  localparam CT_STOPPED = 4'b0001;
  localparam CT_STARTING = 4'b0010;
  localparam CT_RUNNING = 4'b0100;
  localparam CT_STOPPING = 4'b1000;

  function [5:0] evenMap;
    input [31:0] v;
    begin
      evenMap = {v[`IEN_CT_STOPPED], v[`IEN_CT_STARTED], v[`IEN_CT_TIMEOUT],
                 v[`IEN_CAL_DONE], v[`IEN_SLOW_STARTED], v[`IEN_FAST_STARTED]};
    end
  endfunction

  function [31:0] evenUnmap;
    input [5:0] e;
    begin
      evenUnmap = 32'h0;
      evenUnmap[`IEN_FAST_STARTED] = e[`EV_FAST_STARTED];
      evenUnmap[`IEN_SLOW_STARTED] = e[`EV_SLOW_STARTED];
      evenUnmap[`IEN_CAL_DONE] = e[`EV_CAL_DONE];
      evenUnmap[`IEN_CT_TIMEOUT] = e[`EV_CT_TIMEOUT];
      evenUnmap[`IEN_CT_STARTED] = e[`EV_CT_STARTED];
      evenUnmap[`IEN_CT_STOPPED] = e[`EV_CT_STOPPED];
    end
  endfunction

  reg [2:0] hxState;
  reg [2:0] lfState;
  reg [3:0] ctState;
  reg [15:0] hxCount;
  reg [15:0] lfCount;
  reg [15:0] calCount;
  reg [31:0] ctTick;
  reg [6:0] ctCount;
  reg calActive;
  reg fastRequested;
  reg slowRequested;
  reg [5:0] events;
  reg [5:0] irqEnable;
  reg [1:0] selSource;
  reg selExternal;
  reg selBypass;
  reg [1:0] snapSource;
  reg snapExternal;
  reg snapBypass;
  reg [7:0] fastDebounce;
  reg [3:0] slowDebounce;
  reg [6:0] ctInterval;

  wire setupPhase = psel & penable & ~pready;
  wire accessDone = psel & penable & pready;
  wire wr = accessDone & pwrite;
  wire trig = wr & pwdata[0];
  // task pulses last exactly the completing cycle of the write
  wire tFastStart = trig && paddr == `OFS_FAST_XTAL_START;
  wire tFastStop = trig && paddr == `OFS_FAST_XTAL_STOP;
  wire tSlowStart = trig && paddr == `OFS_SLOW_START;
  wire tSlowStop = trig && paddr == `OFS_SLOW_STOP;
  wire tCal = trig && paddr == `OFS_CAL_TASK;
  wire tCtStart = trig && paddr == `OFS_CT_START;
  wire tCtStop = trig && paddr == `OFS_CT_STOP;

  // power-up plus debounce; debounce register scaled to clock cycles
  wire [31:0] hxStartFull = `FAST_POWERUP_CYCLES + fastDebounce * DEBOUNCE_UNIT;
  wire [31:0] lfStartFull = 32'h00000040 + slowDebounce * DEBOUNCE_UNIT;
  wire [31:0] calLoadFull = `CAL_CYCLES;
  // counters are 16 bits wide; larger debounce settings wrap
  wire [15:0] hxStartCycles = hxStartFull[15:0];
  wire [15:0] lfStartCycles = lfStartFull[15:0];
  wire hxDone = (hxState == HX_START) && (hxCount == 16'h0000);
  wire lfSwitch = (lfState == LF_WARM) && (lfCount == 16'h0000);
  wire lfImmediate = tSlowStart && (lfState == LF_OFF) && !systemOff && selSource != `SOURCE_XTAL;
  wire calStart = tCal && !calActive && lfState == LF_RUN && slowActiveSource == `SOURCE_RC;
  wire calDone = calActive && calCount == 16'h0000;
  wire ctTimeout = ctState == CT_RUNNING && ctCount == 7'h00;
  wire [5:0] evSet;
  reg [31:0] rdata;
  reg rdErr;

  // timer started/stopped answers come one cycle after the task, so the busy window is visible
  assign evSet[`EV_FAST_STARTED] = hxDone;
  assign evSet[`EV_SLOW_STARTED] = lfSwitch | lfImmediate;
  assign evSet[`EV_CAL_DONE] = calDone;
  assign evSet[`EV_CT_TIMEOUT] = ctTimeout;
  assign evSet[`EV_CT_STARTED] = ctState == CT_STARTING;
  assign evSet[`EV_CT_STOPPED] = ctState == CT_STOPPING;

  // fast crystal sequencing
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hxState <= HX_OFF;
      hxCount <= 16'h0000;
      fastRequested <= 1'b0;
    end else begin
      if (tFastStart) begin
        fastRequested <= 1'b1;
      end else if (tFastStop) begin
        fastRequested <= 1'b0;
      end
      case (hxState)
        HX_OFF: begin
          if (tFastStart) begin
            hxState <= HX_START;
            hxCount <= hxStartCycles;
          end
        end
        HX_START: begin
          if (tFastStop) begin
            hxState <= HX_OFF;
          end else if (hxCount == 16'h0000) begin
            hxState <= HX_RUN;
          end else begin
            hxCount <= hxCount - 16'h0001;
          end
        end
        HX_RUN: begin
          if (tFastStop) begin
            hxState <= HX_OFF;
          end
        end
        default: hxState <= HX_OFF;
      endcase
    end
  end

  // slow clock sequencing
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfState <= LF_OFF;
      lfCount <= 16'h0000;
      slowRequested <= 1'b0;
      snapSource <= `SOURCE_RC;
      snapExternal <= 1'b0;
      snapBypass <= 1'b0;
      slowActiveSource <= `SOURCE_RC;
    end else if (systemOff) begin
      lfState <= LF_OFF;
      slowRequested <= 1'b0;
    end else begin
      if (tSlowStart) begin
        slowRequested <= 1'b1;
      end else if (tSlowStop) begin
        slowRequested <= 1'b0;
      end
      case (lfState)
        LF_OFF: begin
          if (tSlowStart) begin
            snapSource <= selSource;
            snapExternal <= selExternal;
            snapBypass <= selBypass;
            if (selSource == `SOURCE_XTAL) begin
              lfState <= LF_WARM;
              lfCount <= lfStartCycles;
              slowActiveSource <= `SOURCE_RC;
            end else begin
              lfState <= LF_RUN;
              slowActiveSource <= selSource;
            end
          end
        end
        LF_WARM: begin
          if (tSlowStop) begin
            lfState <= LF_OFF;
          end else if (lfCount == 16'h0000) begin
            lfState <= LF_RUN;
            slowActiveSource <= `SOURCE_XTAL;
          end else begin
            lfCount <= lfCount - 16'h0001;
          end
        end
        LF_RUN: begin
          if (tSlowStop) begin
            lfState <= LF_OFF;
          end
        end
        default: lfState <= LF_OFF;
      endcase
    end
  end

  // rc calibration; a stop during calibration is forbidden to software, here it ends calibration without a done event
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calActive <= 1'b0;
      calCount <= 16'h0000;
    end else if (calStart) begin
      calActive <= 1'b1;
      calCount <= calLoadFull[15:0];
    end else if (calDone || lfState != LF_RUN) begin
      calActive <= 1'b0;
    end else if (calActive) begin
      calCount <= calCount - 16'h0001;
    end
  end

  // calibration timer; tasks are dropped while starting or stopping
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctState <= CT_STOPPED;
      ctCount <= 7'h00;
      ctTick <= 32'h0;
    end else begin
      case (ctState)
        CT_STOPPED: begin
          if (tCtStart) begin
            ctState <= CT_STARTING;
            ctCount <= ctInterval;
            ctTick <= 32'h0;
          end else if (tCtStop) begin
            ctState <= CT_STOPPING;
          end
        end
        CT_STARTING: begin
          ctState <= CT_RUNNING;
        end
        CT_STOPPING: begin
          ctState <= CT_STOPPED;
        end
        CT_RUNNING: begin
          if (tCtStop) begin
            ctState <= CT_STOPPING;
          end else if (tCtStart) begin
            ctState <= CT_STARTING;
          end else if (ctCount == 7'h00) begin
            ctState <= CT_STOPPED;
          end else if (ctTick == CT_TICK_CYCLES - 1) begin
            ctTick <= 32'h0;
            ctCount <= ctCount - 7'h01;
          end else begin
            ctTick <= ctTick + 32'h1;
          end
        end
        default: ctState <= CT_STOPPED;
      endcase
    end
  end

  // config, events and enables; a hardware set wins over a same-cycle software clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      events <= 6'h00;
      irqEnable <= 6'h00;
      selSource <= `SOURCE_RC;
      selExternal <= 1'b0;
      selBypass <= 1'b0;
      fastDebounce <= `FAST_DEBOUNCE_RESET;
      slowDebounce <= `SLOW_DEBOUNCE_RESET;
      ctInterval <= `CT_INTERVAL_RESET;
    end else begin
      if (wr && paddr == `OFS_EV_FAST_STARTED) begin
        events[`EV_FAST_STARTED] <= pwdata[0] | evSet[`EV_FAST_STARTED];
      end else begin
        events[`EV_FAST_STARTED] <= events[`EV_FAST_STARTED] | evSet[`EV_FAST_STARTED];
      end
      if (wr && paddr == `OFS_EV_SLOW_STARTED) begin
        events[`EV_SLOW_STARTED] <= pwdata[0] | evSet[`EV_SLOW_STARTED];
      end else begin
        events[`EV_SLOW_STARTED] <= events[`EV_SLOW_STARTED] | evSet[`EV_SLOW_STARTED];
      end
      if (wr && paddr == `OFS_EV_CAL_DONE) begin
        events[`EV_CAL_DONE] <= pwdata[0] | evSet[`EV_CAL_DONE];
      end else begin
        events[`EV_CAL_DONE] <= events[`EV_CAL_DONE] | evSet[`EV_CAL_DONE];
      end
      if (wr && paddr == `OFS_EV_CT_TIMEOUT) begin
        events[`EV_CT_TIMEOUT] <= pwdata[0] | evSet[`EV_CT_TIMEOUT];
      end else begin
        events[`EV_CT_TIMEOUT] <= events[`EV_CT_TIMEOUT] | evSet[`EV_CT_TIMEOUT];
      end
      if (wr && paddr == `OFS_EV_CT_STARTED) begin
        events[`EV_CT_STARTED] <= pwdata[0] | evSet[`EV_CT_STARTED];
      end else begin
        events[`EV_CT_STARTED] <= events[`EV_CT_STARTED] | evSet[`EV_CT_STARTED];
      end
      if (wr && paddr == `OFS_EV_CT_STOPPED) begin
        events[`EV_CT_STOPPED] <= pwdata[0] | evSet[`EV_CT_STOPPED];
      end else begin
        events[`EV_CT_STOPPED] <= events[`EV_CT_STOPPED] | evSet[`EV_CT_STOPPED];
      end
      if (wr && paddr == `OFS_IRQ_SET) begin
        irqEnable <= irqEnable | evenMap(pwdata);
      end else if (wr && paddr == `OFS_IRQ_CLEAR) begin
        irqEnable <= irqEnable & ~evenMap(pwdata);
      end
      // written while running is a software fault; the running source keeps its snapshot
      if (wr && paddr == `OFS_SLOW_SELECT) begin
        selSource <= pwdata[1:0];
        selExternal <= pwdata[`EXTERNAL_BIT];
        selBypass <= pwdata[`BYPASS_BIT];
      end
      if (wr && paddr == `OFS_FAST_DEBOUNCE) begin
        fastDebounce <= pwdata[7:0];
      end
      if (wr && paddr == `OFS_SLOW_DEBOUNCE) begin
        slowDebounce <= pwdata[3:0];
      end
      if (wr && paddr == `OFS_CT_INTERVAL) begin
        ctInterval <= pwdata[6:0];
      end
    end
  end

  // read decode
  always @* begin
    rdata = 32'h0;
    rdErr = 1'b0;
    if (paddr[11:5] == 7'h00 && paddr[4:0] <= 5'h18 && paddr[1:0] == 2'b00) begin
      rdata = 32'h0;
    end else if (paddr == `OFS_EV_FAST_STARTED) begin
      rdata = {31'h0, events[`EV_FAST_STARTED]};
    end else if (paddr == `OFS_EV_SLOW_STARTED) begin
      rdata = {31'h0, events[`EV_SLOW_STARTED]};
    end else if (paddr == `OFS_EV_CAL_DONE) begin
      rdata = {31'h0, events[`EV_CAL_DONE]};
    end else if (paddr == `OFS_EV_CT_TIMEOUT) begin
      rdata = {31'h0, events[`EV_CT_TIMEOUT]};
    end else if (paddr == `OFS_EV_CT_STARTED) begin
      rdata = {31'h0, events[`EV_CT_STARTED]};
    end else if (paddr == `OFS_EV_CT_STOPPED) begin
      rdata = {31'h0, events[`EV_CT_STOPPED]};
    end else if (paddr == `OFS_IRQ_SET || paddr == `OFS_IRQ_CLEAR) begin
      rdata = evenUnmap(irqEnable);
    end else if (paddr == `OFS_FAST_REQUESTED) begin
      rdata = {31'h0, fastRequested};
    end else if (paddr == `OFS_FAST_STATUS) begin
      rdata[0] = fastFromCrystal;
      rdata[`STATE_BIT] = fastClockEnable;
    end else if (paddr == `OFS_SLOW_REQUESTED) begin
      rdata = {31'h0, slowRequested};
    end else if (paddr == `OFS_SLOW_STATUS) begin
      rdata[1:0] = slowActiveSource;
      rdata[`STATE_BIT] = lfState != LF_OFF;
    end else if (paddr == `OFS_SLOW_SNAPSHOT) begin
      rdata[1:0] = snapSource;
      rdata[`BYPASS_BIT] = snapBypass;
      rdata[`EXTERNAL_BIT] = snapExternal;
    end else if (paddr == `OFS_SLOW_SELECT) begin
      rdata[1:0] = selSource;
      rdata[`BYPASS_BIT] = selBypass;
      rdata[`EXTERNAL_BIT] = selExternal;
    end else if (paddr == `OFS_FAST_DEBOUNCE) begin
      rdata = {24'h0, fastDebounce};
    end else if (paddr == `OFS_SLOW_DEBOUNCE) begin
      rdata = {28'h0, slowDebounce};
    end else if (paddr == `OFS_CT_INTERVAL) begin
      rdata = {25'h0, ctInterval};
    end else begin
      rdErr = 1'b1;
    end
  end

  // APB answer: one wait state, data and error settle with pready
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & rdErr;
      if (setupPhase && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // clock outputs; fast clock only while someone needs it, else it idles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fastClockEnable <= 1'b0;
      fastFromCrystal <= 1'b0;
      fastCrystalOn <= 1'b0;
      slowRcOn <= 1'b0;
      slowCrystalOn <= 1'b0;
      slowCrystalExternal <= 1'b0;
      slowCrystalBypass <= 1'b0;
      slowSynthOn <= 1'b0;
      irq <= 1'b0;
    end else begin
      fastClockEnable <= fastClockRequest | calActive | slowSynthOn;
      fastFromCrystal <= hxState == HX_RUN;
      fastCrystalOn <= hxState != HX_OFF;
      // rc also runs while the crystal warms up, it carries the slow clock meanwhile
      slowRcOn <= !systemOff && (lfState == LF_WARM ||
                  (lfState == LF_RUN && snapSource == `SOURCE_RC));
      slowCrystalOn <= !systemOff && lfState != LF_OFF && snapSource == `SOURCE_XTAL;
      slowCrystalExternal <= snapSource == `SOURCE_XTAL && snapExternal;
      slowCrystalBypass <= snapSource == `SOURCE_XTAL && snapExternal && snapBypass;
      slowSynthOn <= !systemOff && lfState == LF_RUN && snapSource == `SOURCE_SYNTH;
      irq <= |(events & irqEnable);
    end
  end
endmodule // clock_source_control
`default_nettype wire

// ### tb/clock_requester.sv
/*
  partner model: the system modules that ask for the fast clock, and the power-off control.
  assumes the bench sets wantFast and powerOff; outputs change only at clk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_requester (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wantFast,
  input wire logic powerOff,
  output var logic fastClockRequest,
  output var logic systemOff
);
  // registered so requests reach the block as synchronous levels
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fastClockRequest <= 1'b0;
      systemOff <= 1'b0;
    end else begin
      fastClockRequest <= wantFast;
      systemOff <= powerOff;
    end
  end
endmodule // clock_requester
`default_nettype wire

// ### tb/clock_source_control_assertions.sv
/*
  checker for clock_source_control: bus timing and clock source relations at the ports.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_source_control_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fastClockRequest,
  input wire logic systemOff,
  input wire logic fastClockEnable,
  input wire logic fastFromCrystal,
  input wire logic fastCrystalOn,
  input wire logic slowRcOn,
  input wire logic slowCrystalOn,
  input wire logic slowSynthOn,
  input wire logic [1:0] slowActiveSource
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ready_one_wait: assert property (psel && penable && $past(psel && !penable) |=> pready)
    else $error("pready missing one cycle after first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_internal_default: assert property (fastClockEnable && !fastCrystalOn |-> !fastFromCrystal)
    else $error("fast clock from crystal that is not started");
  a_request_served: assert property (fastClockRequest |-> ##[1:2] fastClockEnable)
    else $error("fast clock request not served");
  a_off_stops_slow: assert property (systemOff [*2] |-> !(slowRcOn || slowCrystalOn || slowSynthOn))
    else $error("slow source on during power-off");
  a_synth_holds_fast: assert property (slowSynthOn [*2] |-> fastClockEnable)
    else $error("synthesized slow clock without fast clock");
  a_synth_source_on: assert property (slowSynthOn |-> slowActiveSource == 2'h2)
    else $error("synthesized source on but not active");
  a_crystal_source_on: assert property ($rose(slowActiveSource == 2'h1) |-> slowCrystalOn ##1 !slowRcOn)
    else $error("crystal switch-over without crystal or rc left on");
endmodule // clock_source_control_assertions
`default_nettype wire

// ### tb/test_clock_source_control.sv
/*
  bench for clock_source_control: apb read and write tasks and sequences with expected values.
  assumes the partner model drives clock requests and power-off; small count parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_control_defines.vh"
module test_clock_source_control;
  logic clk, nrst, psel, penable, pwrite, errSeen, wantFast, powerOff;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, fastClockRequest, systemOff, fastClockEnable, fastFromCrystal;
  wire fastCrystalOn, slowRcOn, slowCrystalOn, slowCrystalExternal, slowCrystalBypass;
  wire slowSynthOn, irq;
  wire [1:0] slowActiveSource;
  int fails, checks_done;
  logic [31:0] srcTab [5] = '{32'h0, 32'h1, 32'h00020001, 32'h00030001, 32'h2};
  clock_source_control #(.CT_TICK_CYCLES(4), .DEBOUNCE_UNIT(1)) i_dut (.clk, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fastClockRequest,
    .systemOff, .fastClockEnable, .fastFromCrystal, .fastCrystalOn, .slowRcOn, .slowCrystalOn,
    .slowCrystalExternal, .slowCrystalBypass, .slowSynthOn, .slowActiveSource, .irq);
  clock_requester i_req (.clk, .nrst, .wantFast, .powerOff, .fastClockRequest, .systemOff);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high; one idle edge between transfers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic wait_flag(input logic [11:0] a);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 300);
    check({31'h0, rd[0]}, 32'h1);
    if (rd[0] !== 1'b1) stop_test();
    wr(a, 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    {nrst, psel, penable, pwrite, wantFast, powerOff} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk(`OFS_FAST_DEBOUNCE, 32'h10);
    rchk(`OFS_CT_INTERVAL, 32'h0);
    rchk(`OFS_SLOW_STATUS, 32'h0);
    rchk(`OFS_FAST_REQUESTED, 32'h0);
    rchk(12'h200, 32'h0);
    check(errSeen, 1'b1);
    wr(`OFS_IRQ_SET, 32'hC1B);
    rchk(`OFS_IRQ_SET, 32'hC1B);
    wr(`OFS_IRQ_CLEAR, 32'hC1A);
    rchk(`OFS_IRQ_CLEAR, 32'h1);
    wantFast <= 1'b1;
    wr(`OFS_FAST_XTAL_START, 32'h1);
    rchk(`OFS_FAST_REQUESTED, 32'h1);
    check({fastClockEnable, fastFromCrystal}, 2'b10);
    repeat (200) @(posedge clk);
    rchk(`OFS_EV_FAST_STARTED, 32'h0);
    repeat (15) @(posedge clk);
    check(irq, 1'b1);
    wait_flag(`OFS_EV_FAST_STARTED);
    rchk(`OFS_FAST_STATUS, 32'h00010001);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wantFast <= 1'b0;
    // select always written while the slow clock is stopped
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_SLOW_SELECT, srcTab[i]);
      wr(`OFS_SLOW_START, 32'h1);
      if (srcTab[i][1:0] == 2'h1) begin
        @(posedge clk);
        check({slowRcOn, slowActiveSource}, 3'b100);
      end
      wait_flag(`OFS_EV_SLOW_STARTED);
      check({slowCrystalExternal, slowCrystalBypass, slowActiveSource}, {srcTab[i][17:16],
        srcTab[i][1:0]});
      rchk(`OFS_SLOW_STATUS, {15'h0, 1'b1, 14'h0, srcTab[i][1:0]});
      if (srcTab[i][1:0] == 2'h2) check({slowSynthOn, fastClockEnable}, 2'b11);
      wr(`OFS_SLOW_STOP, 32'h1);
      repeat (2) @(posedge clk);
      check({slowRcOn, slowCrystalOn, slowSynthOn}, 3'b000);
    end
    wr(`OFS_SLOW_SELECT, 32'h0);
    wr(`OFS_SLOW_START, 32'h1);
    wait_flag(`OFS_EV_SLOW_STARTED);
    wr(`OFS_CAL_TASK, 32'h1);
    @(posedge clk);
    check(fastClockEnable, 1'b1);
    wait_flag(`OFS_EV_CAL_DONE);
    repeat (3) @(posedge clk);
    check(fastClockEnable, 1'b0);
    powerOff <= 1'b1;
    repeat (4) @(posedge clk);
    check(slowRcOn, 1'b0);
    powerOff <= 1'b0;
    wr(`OFS_CT_INTERVAL, 32'h2);
    wr(`OFS_CT_STOP, 32'h1);
    wait_flag(`OFS_EV_CT_STOPPED);
    wr(`OFS_CT_START, 32'h1);
    wait_flag(`OFS_EV_CT_STARTED);
    wait_flag(`OFS_EV_CT_TIMEOUT);
    wr(`OFS_CT_INTERVAL, 32'h14);
    wr(`OFS_CT_START, 32'h1);
    wait_flag(`OFS_EV_CT_STARTED);
    wr(`OFS_CT_START, 32'h1);
    rchk(`OFS_EV_CT_STARTED, 32'h1);
    wr(`OFS_CT_STOP, 32'h1);
    wait_flag(`OFS_EV_CT_STOPPED);
    repeat (100) @(posedge clk);
    rchk(`OFS_EV_CT_TIMEOUT, 32'h0);
    stop_test();
  end
endmodule // test_clock_source_control
bind clock_source_control clock_source_control_assertions i_chk (.clk, .nrst, .psel,
  .penable, .pready, .pslverr, .fastClockRequest, .systemOff, .fastClockEnable,
  .fastFromCrystal, .fastCrystalOn, .slowRcOn, .slowCrystalOn, .slowSynthOn,
  .slowActiveSource);
`default_nettype wire
